// File: pkg/asdc_consts.vh
// Register offsets, field positions and reset values of the ALU self-test and diagnostic bank
`ifndef ASDC_CONSTS_VH
`define ASDC_CONSTS_VH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define ASDC_IDX_ARG_ODD_FIRST   8'h67
`define ASDC_IDX_ARG_ODD_SECOND  8'h68
`define ASDC_IDX_ARG_EVEN_FIRST  8'h69
`define ASDC_IDX_ARG_EVEN_SECOND 8'h6a
`define ASDC_IDX_DIAG_CONFIG     8'h6b

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ASDC_ARG_MSB        11
`define ASDC_EN_BIT         15
`define ASDC_LEVEL_MSB      15
`define ASDC_LEVEL_LSB      12
`define ASDC_SRC_BIT        11
`define ASDC_MUX_BUS_BIT    10
`define ASDC_MUX_PAIR_BIT   9
`define ASDC_MUX_EN_BIT     8
`define ASDC_SEL_TWO_MSB    7
`define ASDC_SEL_TWO_LSB    4
`define ASDC_SEL_ONE_MSB    3
`define ASDC_SEL_ONE_LSB    0

// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define ASDC_ARG_RESET      12'h000
`define ASDC_DIAG_RESET     16'h0000
`define ASDC_SCAN_CAL_CODE  3'h3
`define ASDC_GAIN_UNITY     16'h8000
`define ASDC_OFFSET_ZERO    16'h0000

`endif

// File: rtl/asdc_regs.v
// ALU self-test arguments and diagnostic configuration register bank
//
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/100ps
`include "asdc_consts.vh"


module asdc_regs
(
    input wire clk,
    input wire rst_n,
    // Avalon-MM slave, word addressed
    input wire [7:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    output reg [1:0] avs_response,
    // Scan datapath side
    input wire [2:0] scan_configuration,
    input wire balancing_scan,
    input wire oversampling,
    input wire sample_even,
    input wire conversion_second,
    input wire [11:0] adc_result,
    output reg [11:0] alu_operand,
    output reg alu_test_active,
    output reg [15:0] cal_gain,
    output reg [15:0] cal_offset,
    input wire [15:0] cal_gain_coeff,
    input wire [15:0] cal_offset_coeff,
    output wire [3:0] test_current_level,
    output wire test_current_source_select,
    output wire mux_diag_bus_select,
    output wire mux_diag_pair_select,
    output wire mux_diag_enable,
    output wire [3:0] diag_selector_one,
    output wire [3:0] diag_selector_two
);

// ----------------------------------------
// Helpers
// ----------------------------------------
// Byte-lane merge of a write into the current register view
function [15:0] asdc_merge;
    input [15:0] old;
    input [15:0] wdata;
    input [1:0] be;
    begin
        asdc_merge = {be[1] ? wdata[15:8] : old[15:8], be[0] ? wdata[7:0] : old[7:0]};
    end
endfunction

// The map is one contiguous run of word indices
function asdc_is_mapped;
    input [7:0] idx;
    begin
        asdc_is_mapped = (idx >= `ASDC_IDX_ARG_ODD_FIRST) && (idx <= `ASDC_IDX_DIAG_CONFIG);
    end
endfunction

// ----------------------------------------
// Registers
// ----------------------------------------
reg selftest_enable_r;
reg [11:0] alu_test_arg_odd_first_r;
reg [11:0] alu_test_arg_odd_second_r;
reg [11:0] alu_test_arg_even_first_r;
reg [11:0] alu_test_arg_even_second_r;
reg [15:0] diagnostic_config_r;
reg ack_r;
wire [15:0] odd_first_view;
wire [15:0] wr_m_odd_first;
wire [15:0] wr_m_odd_second;
wire [15:0] wr_m_even_first;
wire [15:0] wr_m_even_second;
wire [15:0] wr_m_diag;
wire hit;
wire test_mode;
wire req_start;
wire wr_commit;
reg [15:0] rd_word;

// One wait cycle per access keeps read data registered
assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;

// ----------------------------------------
// Bus decode
// ----------------------------------------
// Read data is captured on the first edge, so it already stands when waitrequest drops
assign req_start = (avs_read | avs_write) & ~ack_r;
// A write lands only on the edge at which the master sees waitrequest low
assign wr_commit = avs_write & ack_r;

assign hit = asdc_is_mapped(avs_address);

assign odd_first_view = {selftest_enable_r, 3'h0, alu_test_arg_odd_first_r};
assign wr_m_odd_first = asdc_merge(odd_first_view, avs_writedata[15:0], avs_byteenable[1:0]);
assign wr_m_odd_second = asdc_merge({4'h0, alu_test_arg_odd_second_r}, avs_writedata[15:0], avs_byteenable[1:0]);
assign wr_m_even_first = asdc_merge({4'h0, alu_test_arg_even_first_r}, avs_writedata[15:0], avs_byteenable[1:0]);
assign wr_m_even_second = asdc_merge({4'h0, alu_test_arg_even_second_r}, avs_writedata[15:0],
                                     avs_byteenable[1:0]);
assign wr_m_diag = asdc_merge(diagnostic_config_r, avs_writedata[15:0], avs_byteenable[1:0]);

// Narrow arguments have no upper storage, so bits 15:12 read zero, except bit 15 of the odd-first word, which reads the self-test enable
always @*
begin
    rd_word = 16'h0000;
    case (avs_address)
        `ASDC_IDX_ARG_ODD_FIRST: rd_word = odd_first_view;
        `ASDC_IDX_ARG_ODD_SECOND: rd_word = {4'h0, alu_test_arg_odd_second_r};
        `ASDC_IDX_ARG_EVEN_FIRST: rd_word = {4'h0, alu_test_arg_even_first_r};
        `ASDC_IDX_ARG_EVEN_SECOND: rd_word = {4'h0, alu_test_arg_even_second_r};
        `ASDC_IDX_DIAG_CONFIG: rd_word = diagnostic_config_r;
        default: rd_word = 16'h0000;
    endcase
end

always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        ack_r <= 1'b0;
        avs_readdata <= 32'h0000_0000;
        avs_response <= 2'h0;
        selftest_enable_r <= 1'b0;
        alu_test_arg_odd_first_r <= `ASDC_ARG_RESET;
        alu_test_arg_odd_second_r <= `ASDC_ARG_RESET;
        alu_test_arg_even_first_r <= `ASDC_ARG_RESET;
        alu_test_arg_even_second_r <= `ASDC_ARG_RESET;
        diagnostic_config_r <= `ASDC_DIAG_RESET;
    end
    else
    begin
        // Toggling lets a request held past completion start afresh
        ack_r <= req_start;
        if (req_start)
        begin
            avs_response <= hit ? 2'h0 : 2'h2;
            // Writes and unmapped reads return zero data
            avs_readdata <= avs_read ? {16'h0000, rd_word} : 32'h0000_0000;
        end
        if (wr_commit)
        begin
            case (avs_address)
                `ASDC_IDX_ARG_ODD_FIRST:
                begin
                    selftest_enable_r <= wr_m_odd_first[`ASDC_EN_BIT];
                    alu_test_arg_odd_first_r <= wr_m_odd_first[`ASDC_ARG_MSB:0];
                end
                `ASDC_IDX_ARG_ODD_SECOND: alu_test_arg_odd_second_r <= wr_m_odd_second[`ASDC_ARG_MSB:0];
                `ASDC_IDX_ARG_EVEN_FIRST: alu_test_arg_even_first_r <= wr_m_even_first[`ASDC_ARG_MSB:0];
                `ASDC_IDX_ARG_EVEN_SECOND: alu_test_arg_even_second_r <= wr_m_even_second[`ASDC_ARG_MSB:0];
                `ASDC_IDX_DIAG_CONFIG: diagnostic_config_r <= wr_m_diag;
                default: diagnostic_config_r <= diagnostic_config_r;
            endcase
        end
    end
end

// ----------------------------------------
// Diagnostic configuration outputs
// ----------------------------------------
// Current per step is set by the analog source; only the code is held here
// Selector codes pass through untouched; their meaning lies with the analog side
assign test_current_level = diagnostic_config_r[`ASDC_LEVEL_MSB:`ASDC_LEVEL_LSB];
assign test_current_source_select = diagnostic_config_r[`ASDC_SRC_BIT];
assign mux_diag_bus_select = diagnostic_config_r[`ASDC_MUX_BUS_BIT];
assign mux_diag_pair_select = diagnostic_config_r[`ASDC_MUX_PAIR_BIT];
assign mux_diag_enable = diagnostic_config_r[`ASDC_MUX_EN_BIT];
assign diag_selector_two = diagnostic_config_r[`ASDC_SEL_TWO_MSB:`ASDC_SEL_TWO_LSB];
assign diag_selector_one = diagnostic_config_r[`ASDC_SEL_ONE_MSB:`ASDC_SEL_ONE_LSB];

// ----------------------------------------
// ALU operand selection
// ----------------------------------------
// Calibration and balancing scans must never see fake data
assign test_mode = selftest_enable_r &
                   (scan_configuration != `ASDC_SCAN_CAL_CODE) &
                   ~balancing_scan;

always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        alu_operand <= 12'h000;
        alu_test_active <= 1'b0;
        cal_gain <= 16'h0000;
        cal_offset <= 16'h0000;
    end
    else
    begin
        alu_test_active <= test_mode;
        // Operand, flag and coefficients move together so the ALU sees one coherent cycle
        alu_operand <= adc_result;
        cal_gain <= cal_gain_coeff;
        cal_offset <= cal_offset_coeff;
        if (test_mode)
        begin
            cal_gain <= `ASDC_GAIN_UNITY;
            cal_offset <= `ASDC_OFFSET_ZERO;
            if (!sample_even)
                alu_operand <= conversion_second ? alu_test_arg_odd_second_r
                                                 : alu_test_arg_odd_first_r;
            // Even samples without oversampling keep the live conversion
            else if (oversampling)
                alu_operand <= conversion_second ? alu_test_arg_even_second_r
                                                 : alu_test_arg_even_first_r;
        end
    end
end

endmodule // asdc_regs

// File: tb/asdc_scan_src.sv
// Random scan sample context standing in for the scan datapath
`timescale 1ns/100ps
module asdc_scan_src
(
    input wire clk,
    output logic [2:0] scan_configuration = 3'h0,
    output logic balancing_scan = 1'b0,
    output logic oversampling = 1'b0,
    output logic sample_even = 1'b0,
    output logic conversion_second = 1'b0,
    output logic [11:0] adc_result = 12'h000,
    output logic [15:0] cal_gain_coeff = 16'h0000,
    output logic [15:0] cal_offset_coeff = 16'h0000
);
    int seed = 7656;
    // New sample context every cycle, so every code and sample slot recurs
    always @(posedge clk)
    begin
        {scan_configuration, balancing_scan, oversampling, sample_even, conversion_second, adc_result}
            <= 19'($random(seed));
        {cal_gain_coeff, cal_offset_coeff} <= $random(seed);
    end
endmodule // asdc_scan_src

// File: tb/asdc_regs_props.sv
// Port-level assertions for the ALU self-test register bank
`timescale 1ns/100ps
module asdc_regs_props
(
    input logic clk,
    input logic rst_n,
    input logic [7:0] avs_address,
    input logic avs_read,
    input logic avs_write,
    input logic [31:0] avs_readdata,
    input logic avs_waitrequest,
    input logic [1:0] avs_response,
    input logic [2:0] scan_configuration,
    input logic balancing_scan,
    input logic oversampling,
    input logic sample_even,
    input logic [11:0] adc_result,
    input logic [11:0] alu_operand,
    input logic alu_test_active,
    input logic [15:0] cal_gain,
    input logic [15:0] cal_offset
);
    logic [2:0] up_r;
    logic done;
    assign done = (avs_read || avs_write) && !avs_waitrequest;
    // $past has no history on the first edges after reset release, so skip those edges
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
            up_r <= 3'h0;
        else
            up_r <= {up_r[1:0], 1'b1};
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_ONE_WAIT: assert property (up_r[2] && (avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest)
        else $error("wait state too long");
    AST_RD_NARROW: assert property (done && avs_read && avs_address inside {[8'h68:8'h6a]}
        |-> avs_readdata[31:12] == 20'h0)
        else $error("upper argument bits set");
    AST_RD_ENABLE: assert property (done && avs_read && avs_address == 8'h67
        |-> avs_readdata[31:16] == 16'h0 && avs_readdata[14:12] == 3'h0)
        else $error("unused bits set");
    AST_UNMAPPED: assert property (done && !(avs_address inside {[8'h67:8'h6b]}) |-> avs_response == 2'b10)
        else $error("unmapped not refused");
    AST_MAPPED_OK: assert property (done && avs_address inside {[8'h67:8'h6b]} |-> avs_response == 2'b00)
        else $error("mapped refused");
    AST_CAL_SKIP: assert property (scan_configuration == 3'h3 || balancing_scan |=> !alu_test_active)
        else $error("test mode not ignored");
    AST_UNITY: assert property (alu_test_active |-> cal_gain == 16'h8000 && cal_offset == 16'h0000)
        else $error("calibration applied");
    AST_NORMAL_PATH: assert property (up_r[2] && !alu_test_active |-> alu_operand == $past(adc_result))
        else $error("conversion not passed");
    AST_EVEN_PLAIN: assert property (up_r[2] && $past(sample_even && !oversampling)
        |-> alu_operand == $past(adc_result))
        else $error("even sample replaced");
    cover property (done && avs_write);
    cover property (alu_test_active);
    cover property (done && avs_response == 2'b10);
endmodule // asdc_regs_props
bind asdc_regs asdc_regs_props u_props (.*);

// File: tb/test_alu_selftest_diag_config_regs.sv
// Self-checking bench for the ALU self-test and diagnostic register bank
`timescale 1ns/100ps
module test_alu_selftest_diag_config_regs;
    logic clk = 0, rst_n = 0, avs_read = 0, avs_write = 0;
    logic [7:0] avs_address = 8'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata;
    logic [3:0] avs_byteenable = 4'h0, test_current_level, diag_selector_one, diag_selector_two;
    logic [1:0] avs_response;
    logic [2:0] scan_configuration;
    logic [11:0] adc_result, alu_operand;
    logic [15:0] cal_gain, cal_offset, cal_gain_coeff, cal_offset_coeff;
    logic avs_waitrequest, balancing_scan, oversampling, sample_even, conversion_second, alu_test_active;
    logic test_current_source_select, mux_diag_bus_select, mux_diag_pair_select, mux_diag_enable;
    logic [15:0] m [5] = '{default: 16'h0};
    int fails = 0, cmp_count = 0, seed = 7656;
    asdc_regs DUT (.*);
    asdc_scan_src u_scan (.*);
    always #2 clk = ~clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d, input logic [3:0] be);
        logic hit;
        logic [15:0] k, mk;
        hit = a > 8'h66 && a < 8'h6c;
        mk = a == 8'h67 ? 16'h8fff : (a == 8'h6b ? 16'hffff : 16'h0fff);
        @(posedge clk);
        avs_address <= a;
        avs_read <= !w;
        avs_write <= w;
        avs_writedata <= {16'h0000, d};
        avs_byteenable <= be;
        do
            @(posedge clk);
        while (avs_waitrequest !== 1'b0);
        k = hit ? m[a - 8'h67] : 16'h0000;
        if (!w)
            chk(avs_readdata, {16'h0000, k});
        chk({30'h0, avs_response}, hit ? 32'h0 : 32'h2);
        if (w && hit)
            m[a - 8'h67] = {be[1] ? d[15:8] : k[15:8], be[0] ? d[7:0] : k[7:0]} & mk;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    // Negedge sampling keeps clear of the partner's edge updates
    task automatic scan(input int cyc);
        logic ea;
        logic [11:0] eo;
        logic [31:0] ec;
        @(negedge clk);
        repeat (cyc)
        begin
            ea = m[0][15] && scan_configuration != 3'h3 && !balancing_scan;
            eo = ea && !(sample_even && !oversampling) ? m[{sample_even, conversion_second}][11:0] : adc_result;
            ec = ea ? 32'h8000_0000 : {cal_gain_coeff, cal_offset_coeff};
            @(negedge clk);
            chk({20'h0, alu_operand}, {20'h0, eo});
            chk({31'h0, alu_test_active}, {31'h0, ea});
            chk({cal_gain, cal_offset}, ec);
        end
    endtask
    task close_out;
        $display("errors %0d compares %0d", fails, cmp_count);
        if (fails == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        for (int r = 0; r < 8; r++)
        begin
            for (int a = 8'h66; a < 8'h6d; a++)
                xfer(1'b0, 8'(a), 16'h0000, 4'hf);
            chk({16'h0, test_current_level, test_current_source_select, mux_diag_bus_select, mux_diag_pair_select,
                mux_diag_enable, diag_selector_two, diag_selector_one}, {16'h0, m[4]});
            scan(60);
            for (int a = 8'h66; a < 8'h6d; a++)
                xfer(1'b1, 8'(a), 16'($random(seed)) | {r[0], 15'h0}, 4'($random(seed)) | {2'b00, r[0], 1'b0});
        end
        close_out;
    end
    initial
    begin
        #100000;
        fails++;
        close_out;
    end
endmodule // test_alu_selftest_diag_config_regs
